// ===== rtl/uhr_pkg.sv
// Package of constants for the USB high-speed redriver strap and status logic
// Function
// RULE_01 - At reset release, both serial lines high selects serial mode, else strap mode.
// RULE_02 - Serial mode answers as target at seven-bit address 0x2C only.
// RULE_03 - Strap mode samples three-level DC gain strap: high 80, open 60, low 40 mV.
// RULE_04 - After reset in strap mode, DC gain pin outputs the high-speed flag.
// RULE_05 - Flag set after test fixture seen from unconnected, then test packet sent.
// RULE_06 - Flag set on squelch after bus reset with successful high-speed handshake.
// RULE_07 - Handshake succeeds on one chirp J then chirp K, each 18 to 128 us.
// RULE_08 - In strap mode serial clock pin outputs attach flag, set on pull-up seen.
// RULE_09 - Attach flag clears when device disconnect is detected.
// RULE_10 - Enable low holds device in reset and shutdown; high runs normally.
// RULE_11 - Outside logic keeps enable low until supply is settled.
// RULE_12 - Core regulator output enabled only while in high-speed mode.
// RULE_13 - AC gain strap sampled once at enable release; later changes ignored.
// RULE_14 - High-speed flag clears on leaving high speed, disconnect or reset.
package uhr_pkg;

  localparam logic [6:0] UHR_I2C_ADDR = 7'h2C;
  localparam int UHR_CLK_MHZ = 125;
  localparam int UHR_CHIRP_MIN_US = 18;
  localparam int UHR_CHIRP_MAX_US = 128;
  localparam int UHR_CHIRP_MIN_CYC = UHR_CHIRP_MIN_US * UHR_CLK_MHZ;
  localparam int UHR_CHIRP_MAX_CYC = UHR_CHIRP_MAX_US * UHR_CLK_MHZ;
  localparam int UHR_CNT_W = 15;

  // DC gain strap codes and the DC and AC gain reset values
  localparam logic [1:0] UHR_DC_40MV = 2'h0;
  localparam logic [1:0] UHR_DC_60MV = 2'h1;
  localparam logic [1:0] UHR_DC_80MV = 2'h2;
  localparam logic [1:0] UHR_DC_RST = UHR_DC_60MV;
  localparam logic [1:0] UHR_AC_RST = 2'h3;

  typedef enum logic [5:0] {
    UHR_ST_UNCONN = 6'h01,
    UHR_ST_FIXTURE = 6'h02,
    UHR_ST_CONN = 6'h04,
    UHR_ST_CHIRP_J = 6'h08,
    UHR_ST_CHIRP_K = 6'h10,
    UHR_ST_HS_WAIT = 6'h20
  } uhr_state_t;

endpackage

// ===== rtl/uhr_chirp_timer.sv
// Chirp duration window checker
`timescale 1ns/10ps
module uhr_chirp_timer
  import uhr_pkg::*;
#(
  parameter int MIN_CYC = UHR_CHIRP_MIN_CYC,
  parameter int MAX_CYC = UHR_CHIRP_MAX_CYC
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic run,
  output logic in_window,
  output logic too_long
);

  logic [UHR_CNT_W-1:0] cnt_reg;

  always_ff @(posedge ref_clk) begin
    if (sys_rst || !run) begin
      cnt_reg <= '0;
    end else if (cnt_reg != MAX_CYC[UHR_CNT_W-1:0] + 15'h0001) begin
      cnt_reg <= cnt_reg + 15'h0001;
    end
  end

  // Length so far is cnt_reg + 2 cycles, the state entry cycle included
  assign in_window = run && (cnt_reg >= MIN_CYC[UHR_CNT_W-1:0] - 15'h0002)
                     && (cnt_reg <= MAX_CYC[UHR_CNT_W-1:0] - 15'h0002); // [RULE_07]
  assign too_long = run && (cnt_reg >= MAX_CYC[UHR_CNT_W-1:0] - 15'h0001); // [RULE_07]

endmodule

// ===== rtl/uhr_strap_status.sv
// Mode select, strap sampling and status flags of the USB high-speed redriver
`timescale 1ns/10ps
module uhr_strap_status
  import uhr_pkg::*;
#(
  parameter int CHIRP_MIN_CYC = UHR_CHIRP_MIN_CYC,
  parameter int CHIRP_MAX_CYC = UHR_CHIRP_MAX_CYC
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic active_low_enable,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic dc_strap_high,
  input wire logic dc_strap_low,
  input wire logic [1:0] ac_gain_strap,
  input wire logic pullup_seen,
  input wire logic disconnect_seen,
  input wire logic fixture_seen,
  input wire logic test_packet_seen,
  input wire logic bus_reset,
  input wire logic chirp_j,
  input wire logic chirp_k,
  input wire logic squelch,
  input wire logic hs_exit,
  input wire logic [6:0] i2c_addr_in,
  input wire logic i2c_addr_valid,
  output logic i2c_mode,
  output logic i2c_addr_match,
  output logic [1:0] dc_gain_sel,
  output logic [1:0] ac_gain_sel,
  output logic hs_active_flag,
  output logic dc_gain_strap_out,
  output logic dc_gain_strap_oe,
  output logic attach_detect_flag,
  output logic scl_out,
  output logic scl_oe,
  output logic core_regulator_out
);

  // ==========================================================================
  // Reset and strap capture
  // ==========================================================================
  logic held_reg;
  logic i2c_mode_reg;
  logic [1:0] dc_gain_reg;
  logic [1:0] ac_gain_reg;
  logic in_rst;

  assign in_rst = sys_rst || !active_low_enable; // [RULE_10]

  always_ff @(posedge ref_clk) begin
    held_reg <= in_rst;
  end

  // Straps are caught on the first cycle after enable release, then frozen
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      i2c_mode_reg <= 1'b0;
      dc_gain_reg <= UHR_DC_RST;
      ac_gain_reg <= UHR_AC_RST;
    end else if (held_reg && active_low_enable) begin
      i2c_mode_reg <= scl_in && sda_in; // [RULE_01]
      ac_gain_reg <= ac_gain_strap; // [RULE_13]
      if (dc_strap_high) begin
        dc_gain_reg <= UHR_DC_80MV; // [RULE_03]
      end else if (dc_strap_low) begin
        dc_gain_reg <= UHR_DC_40MV; // [RULE_03]
      end else begin
        dc_gain_reg <= UHR_DC_60MV; // [RULE_03]
      end
    end
  end

  logic strap_mode;
  assign strap_mode = !i2c_mode_reg && !in_rst;

  // ==========================================================================
  // Link state machine
  // ==========================================================================
  uhr_state_t state_reg;
  uhr_state_t state_next;
  logic hs_reg;
  logic hs_set;
  logic chirp_ok;
  logic chirp_long;
  logic chirp_run;
  logic chirp_level;
  // Window result held from the last cycle the chirp was still driven
  logic chirp_ok_j_reg;
  logic chirp_ok_k_reg;

  assign chirp_level = (state_reg == UHR_ST_CHIRP_J) ? chirp_j : chirp_k;
  assign chirp_run = ((state_reg == UHR_ST_CHIRP_J) || (state_reg == UHR_ST_CHIRP_K)) && chirp_level;

  uhr_chirp_timer #(
    .MIN_CYC(CHIRP_MIN_CYC),
    .MAX_CYC(CHIRP_MAX_CYC)
  ) u_chirp (
    .ref_clk(ref_clk),
    .sys_rst(in_rst),
    .run(chirp_run),
    .in_window(chirp_ok),
    .too_long(chirp_long)
  );

  always_comb begin
    state_next = state_reg;
    hs_set = 1'b0;
    if (disconnect_seen && (state_reg != UHR_ST_UNCONN)) begin
      state_next = UHR_ST_UNCONN; // [RULE_09]
    end else begin
      unique case (state_reg)
        UHR_ST_UNCONN: begin
          if (fixture_seen) begin
            state_next = UHR_ST_FIXTURE;
          end else if (pullup_seen) begin
            state_next = UHR_ST_CONN; // [RULE_08]
          end
        end
        UHR_ST_FIXTURE: begin
          if (test_packet_seen) begin
            hs_set = 1'b1; // [RULE_05]
            state_next = UHR_ST_CONN;
          end
        end
        UHR_ST_CONN: begin
          if (bus_reset && chirp_j) begin
            state_next = UHR_ST_CHIRP_J;
          end
        end
        UHR_ST_CHIRP_J: begin
          if (chirp_long) begin
            state_next = UHR_ST_CONN;
          end else if (!chirp_j) begin
            state_next = (chirp_k && chirp_ok_j_reg) ? UHR_ST_CHIRP_K : UHR_ST_CONN; // [RULE_07]
          end
        end
        UHR_ST_CHIRP_K: begin
          if (chirp_long) begin
            state_next = UHR_ST_CONN;
          end else if (!chirp_k) begin
            state_next = chirp_ok_k_reg ? UHR_ST_HS_WAIT : UHR_ST_CONN; // [RULE_07]
          end
        end
        UHR_ST_HS_WAIT: begin
          if (squelch) begin
            hs_set = 1'b1; // [RULE_06]
            state_next = UHR_ST_CONN;
          end else if (bus_reset && chirp_j) begin
            state_next = UHR_ST_CHIRP_J;
          end
        end
        default: begin
          state_next = UHR_ST_UNCONN;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (in_rst) begin
      chirp_ok_j_reg <= 1'b0;
      chirp_ok_k_reg <= 1'b0;
    end else begin
      chirp_ok_j_reg <= (state_reg == UHR_ST_CHIRP_J) && chirp_ok;
      chirp_ok_k_reg <= (state_reg == UHR_ST_CHIRP_K) && chirp_ok;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (in_rst) begin
      state_reg <= UHR_ST_UNCONN; // [RULE_10]
    end else begin
      state_reg <= state_next;
    end
  end

  // Set wins over a same-cycle exit
  always_ff @(posedge ref_clk) begin
    if (in_rst) begin
      hs_reg <= 1'b0; // [RULE_14]
    end else if (hs_set) begin
      hs_reg <= 1'b1;
    end else if (hs_exit || (state_next == UHR_ST_UNCONN) || (bus_reset && chirp_j)) begin
      hs_reg <= 1'b0; // [RULE_14]
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  logic attach_reg;

  always_ff @(posedge ref_clk) begin
    if (in_rst) begin
      attach_reg <= 1'b0;
    end else begin
      attach_reg <= (state_next != UHR_ST_UNCONN); // [RULE_08] [RULE_09]
    end
  end

  assign i2c_mode = i2c_mode_reg;
  assign i2c_addr_match = i2c_mode_reg && !in_rst && i2c_addr_valid && (i2c_addr_in == UHR_I2C_ADDR); // [RULE_02]
  assign dc_gain_sel = dc_gain_reg;
  assign ac_gain_sel = ac_gain_reg;
  assign hs_active_flag = hs_reg;
  assign dc_gain_strap_out = hs_reg; // [RULE_04]
  assign dc_gain_strap_oe = strap_mode; // [RULE_04]
  assign attach_detect_flag = attach_reg;
  assign scl_out = attach_reg; // [RULE_08]
  assign scl_oe = strap_mode; // [RULE_08]
  assign core_regulator_out = hs_reg; // [RULE_12]

endmodule

// ===== test/uhr_strap_status_monitor.sv
// Checker bound to the strap and status logic
`timescale 1ns/10ps
module uhr_strap_status_monitor
  import uhr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic active_low_enable,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic [1:0] ac_gain_strap,
  input wire logic disconnect_seen,
  input wire logic [6:0] i2c_addr_in,
  input wire logic i2c_addr_valid,
  input wire logic i2c_mode,
  input wire logic i2c_addr_match,
  input wire logic [1:0] dc_gain_sel,
  input wire logic [1:0] ac_gain_sel,
  input wire logic hs_active_flag,
  input wire logic dc_gain_strap_out,
  input wire logic attach_detect_flag,
  input wire logic core_regulator_out
);
  // Two-cycle history of running out of reset, marks the strap sampling edge
  logic [1:0] run_q;
  always_ff @(posedge ref_clk) begin
    run_q <= {run_q[0], active_low_enable & ~sys_rst};
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  property p_reg; core_regulator_out == hs_active_flag; endproperty
  a_reg: assert property (p_reg) else $error("regulator not tracking hs flag");
  property p_out; dc_gain_strap_out == hs_active_flag; endproperty
  a_out: assert property (p_out) else $error("strap pin not showing hs flag");
  property p_match;
    i2c_addr_match == (i2c_mode && active_low_enable && i2c_addr_valid && i2c_addr_in == UHR_I2C_ADDR);
  endproperty
  a_match: assert property (p_match) else $error("address match wrong");
  property p_mode; run_q == 2'h1 |-> i2c_mode == $past(scl_in & sda_in); endproperty
  a_mode: assert property (p_mode) else $error("mode not taken at release");
  property p_ac; run_q == 2'h1 |-> ac_gain_sel == $past(ac_gain_strap); endproperty
  a_ac: assert property (p_ac) else $error("ac strap not sampled");
  property p_hold; run_q == 2'h3 |-> $stable(ac_gain_sel) && $stable(dc_gain_sel) && $stable(i2c_mode); endproperty
  a_hold: assert property (p_hold) else $error("strap value moved after release");
  property p_rst; !active_low_enable |=> !hs_active_flag && !attach_detect_flag; endproperty
  a_rst: assert property (p_rst) else $error("flags set while disabled");
  property p_disc; disconnect_seen |=> !attach_detect_flag; endproperty
  a_disc: assert property (p_disc) else $error("attach flag held after disconnect");
  c_hs: cover property ($rose(hs_active_flag));
  c_att: cover property ($rose(attach_detect_flag));
  c_i2c: cover property (i2c_addr_match);
endmodule
bind uhr_strap_status uhr_strap_status_monitor mon (.*);

// ===== test/uhr_usb_peer.sv
// Far-side USB device model: attach, chirp handshake and squelch
`timescale 1ns/10ps
module uhr_usb_peer (
  input wire logic ref_clk,
  output logic pullup_seen,
  output logic bus_reset,
  output logic chirp_j,
  output logic chirp_k,
  output logic squelch
);
  initial begin
    {pullup_seen, bus_reset, chirp_j, chirp_k, squelch} = 5'h00;
  end
  task automatic attach();
    @(negedge ref_clk);
    pullup_seen = 1'b1;
    @(negedge ref_clk);
    pullup_seen = 1'b0;
  endtask
  // Bus reset, one J then one K of the given lengths in cycles, then squelch
  task automatic handshake(input int jl, input int kl);
    @(negedge ref_clk);
    bus_reset = 1'b1;
    chirp_j = 1'b1;
    @(negedge ref_clk);
    bus_reset = 1'b0;
    repeat (jl - 1) @(negedge ref_clk);
    chirp_j = 1'b0;
    chirp_k = 1'b1;
    repeat (kl) @(negedge ref_clk);
    chirp_k = 1'b0;
    @(negedge ref_clk);
    squelch = 1'b1;
    @(negedge ref_clk);
    squelch = 1'b0;
  endtask
endmodule

// ===== test/tb.sv
// Testbench for the strap and status logic
`timescale 1ns/10ps
module tb
  import uhr_pkg::*;
;
  logic ref_clk = 1'b0, sys_rst = 1'b1, active_low_enable = 1'b1, scl_in = 1'b0, sda_in = 1'b0;
  logic dc_strap_high = 1'b0, dc_strap_low = 1'b0, disconnect_seen = 1'b0, fixture_seen = 1'b0;
  logic test_packet_seen = 1'b0, hs_exit = 1'b0, i2c_addr_valid = 1'b0;
  logic [1:0] ac_gain_strap = 2'h3;
  logic [6:0] i2c_addr_in = UHR_I2C_ADDR;
  logic pullup_seen, bus_reset, chirp_j, chirp_k, squelch, i2c_mode, i2c_addr_match, hs_active_flag;
  logic dc_gain_strap_out, dc_gain_strap_oe, attach_detect_flag, scl_out, scl_oe, core_regulator_out;
  logic [1:0] dc_gain_sel, ac_gain_sel;
  logic [1:0] dc_pins [3] = '{2'h2, 2'h0, 2'h1};
  logic [1:0] dc_exp [3] = '{UHR_DC_80MV, UHR_DC_60MV, UHR_DC_40MV};
  int err_count = 0;
  int n_compared = 0;
  always #4 ref_clk = ~ref_clk;
  uhr_strap_status #(.CHIRP_MIN_CYC(4), .CHIRP_MAX_CYC(20)) uut (.*);
  uhr_usb_peer peer (.*);
  task automatic chk(input logic [1:0] got, input logic [1:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    if (err_count == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic pulse(input logic [2:0] m);
    @(negedge ref_clk);
    {fixture_seen, test_packet_seen, disconnect_seen} = m;
    @(negedge ref_clk);
    {fixture_seen, test_packet_seen, disconnect_seen} = 3'h0;
  endtask
  // Disable, set the straps, then release the enable
  task automatic boot(input logic [1:0] dc, input logic [1:0] ac, input logic ser);
    @(negedge ref_clk);
    active_low_enable = 1'b0;
    {dc_strap_high, dc_strap_low} = dc;
    ac_gain_strap = ac;
    {scl_in, sda_in} = {ser, ser};
    repeat (2) @(negedge ref_clk);
    active_low_enable = 1'b1;
    repeat (2) @(negedge ref_clk);
  endtask
  initial begin
    repeat (5) @(negedge ref_clk);
    sys_rst = 1'b0;
    for (int i = 0; i < 3; i++) begin
      boot(dc_pins[i], 2'(i), 1'b0);
      chk(dc_gain_sel, dc_exp[i]);
      chk(ac_gain_sel, 2'(i));
    end
    boot(2'h0, 2'h3, 1'b1);
    ac_gain_strap = 2'h0;
    i2c_addr_valid = 1'b1;
    #1 chk({i2c_mode, i2c_addr_match}, 2'h3);
    chk({dc_gain_strap_oe, scl_oe}, 2'h0);
    i2c_addr_in = 7'h2D;
    #1 chk({i2c_mode, i2c_addr_match}, 2'h2);
    repeat (2) @(negedge ref_clk);
    chk(ac_gain_sel, 2'h3);
    boot(2'h2, 2'h3, 1'b0);
    chk({dc_gain_strap_oe, scl_oe}, 2'h3);
    peer.attach();
    chk({attach_detect_flag, scl_out}, 2'h3);
    peer.handshake(2, 10);
    chk({hs_active_flag, core_regulator_out}, 2'h0);
    peer.handshake(10, 30);
    chk({hs_active_flag, core_regulator_out}, 2'h0);
    peer.handshake(3, 10);
    chk({hs_active_flag, core_regulator_out}, 2'h0);
    peer.handshake(4, 20);
    chk({hs_active_flag, core_regulator_out}, 2'h3);
    peer.handshake(10, 21);
    chk({hs_active_flag, core_regulator_out}, 2'h0);
    peer.handshake(10, 10);
    chk({hs_active_flag, core_regulator_out}, 2'h3);
    pulse(3'h1);
    chk({attach_detect_flag, hs_active_flag}, 2'h0);
    pulse(3'h4);
    pulse(3'h2);
    chk({hs_active_flag, dc_gain_strap_out}, 2'h3);
    hs_exit = 1'b1;
    @(negedge ref_clk);
    hs_exit = 1'b0;
    chk({hs_active_flag, core_regulator_out}, 2'h0);
    active_low_enable = 1'b0;
    repeat (2) @(negedge ref_clk);
    chk({hs_active_flag, attach_detect_flag}, 2'h0);
    stop_test();
  end
endmodule
